// File: rtl/file_set_and_sleep_ops.sv
// execution core for the set-all-ones and sleep instructions behind axi4-lite
// Summary of operation
// - a=0 selects access bank: bank 0 below 80h, bank f from 80h up
// - a=1 uses bank select register bank
// - sleep clears power-down flag
// - sleep sets time-out flag
// - sleep clears watchdog and postscaler
// - sleep halts oscillator and fetching
// - watchdog wake clears time-out flag
`timescale 1ns/1ps
`default_nettype none
module file_set_and_sleep_ops (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic osc_run,
    output logic irq
);
    import fso_pkg::*;

    // four-phase instruction cycle; idle sits between instructions so a new
    // word is only decoded once the previous pass has written back
    typedef enum logic [4:0] {
        st_idle = 5'b00001,
        st_q1 = 5'b00010,
        st_q2 = 5'b00100,
        st_q3 = 5'b01000,
        st_q4 = 5'b10000
    } phase_t;

    phase_t phase; // current q phase
    phase_t next_phase;
    logic [15:0] instr; // instruction word latched for execution
    logic [3:0] bank_select_reg; // current bank
    logic timeout_flag; // active-low sense: 1 means no time-out
    logic powerdown_flag; // 0 after sleep
    logic [4:0] alu_flags; // arithmetic flags, untouched here
    logic asleep; // core in sleep, oscillator stopped
    logic pending; // instruction waiting to run
    wire [ev_w-1:0] status; // sticky events, one flop each in g_event
    logic [ev_w-1:0] mask; // interrupt enables
    logic [7:0] read_val; // value read in q2
    logic [7:0] mem_rdata; // registered file register contents
    // watchdog taps, shown in the flags word
    logic [7:0] wdt_count;
    logic [7:0] wdt_post;

    // axi state
    logic aw_held; // write address captured, waiting for the response
    logic w_held; // write data captured, waiting for the response
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // decode as wires; the word is held in instr for the whole q1..q4 pass,
    // so decode never sees a half-written instruction from the bus
    wire is_set = (instr[15:9] == set_opcode_hi);
    wire is_sleep = (instr == sleep_opcode);
    wire [7:0] file_addr = instr[7:0];
    wire use_bank = instr[a_bit];
    // access bank: low half from bank 0, high half from the sfr bank
    wire [3:0] access_sel = file_addr[7] ? access_bank_hi : access_bank;
    wire [3:0] eff_bank = use_bank ? bank_select_reg : access_sel;
    wire [addr_w-1:0] eff_addr = {eff_bank, file_addr};
    wire mem_we = (phase == st_q4) && is_set;
    wire wdt_clear = (phase == st_q4) && is_sleep;
    wire run = ce && !asleep;
    wire do_write = aw_held && w_held && !s_axi_bvalid; // both halves in, answer next edge
    wire b_done = s_axi_bvalid && s_axi_bready; // response taken, frees the write slot
    wire wr_ctrl = do_write && (aw_addr == axi_ctrl);
    wire wr_mask = do_write && (aw_addr == axi_mask);
    wire wr_instr = do_write && (aw_addr == axi_instr);
    wire wr_bank = do_write && (aw_addr == axi_bank);
    wire wr_hit = wr_ctrl || wr_mask || wr_instr || wr_bank;
    // wake request only meaningful while asleep
    wire wdt_wake = wr_ctrl && w_strb[0] && w_data[0] && asleep;
    wire rd_go = s_axi_arvalid && !s_axi_rvalid;
    wire rd_status = rd_go && (s_axi_araddr == axi_status);
    wire [ev_w-1:0] ev_now = {wdt_wake, wdt_clear, mem_we};
    // events only count from a running core or from the wake write itself
    wire [ev_w-1:0] ev_live = ev_now & {ev_w{run || wdt_wake}};

    // register words seen by a read; the watchdog sits on top of flags so
    // software can see it restart after sleep
    wire [31:0] status_word = {29'h0, status};
    wire [31:0] mask_word = {29'h0, mask};
    wire [31:0] flags_word = {wdt_post, wdt_count, read_val, asleep, bank_select_reg,
        powerdown_flag, timeout_flag, 1'b0};
    wire [31:0] instr_word = {pending, 15'h0, instr};
    wire [31:0] bank_word = {28'h0, bank_select_reg};

    // read mux by if/else-if chain
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb begin
        rd_mux = '0;
        rd_ok = 1'b1;
        if (s_axi_araddr == axi_status) begin
            rd_mux = status_word;
        end else if (s_axi_araddr == axi_mask) begin
            rd_mux = mask_word;
        end else if (s_axi_araddr == axi_flags) begin
            rd_mux = flags_word;
        end else if (s_axi_araddr == axi_instr) begin
            rd_mux = instr_word;
        end else if (s_axi_araddr == axi_bank) begin
            rd_mux = bank_word;
        end else if (s_axi_araddr == axi_ctrl) begin
            rd_mux = '0;
        end else begin
            rd_ok = 1'b0; // unmapped
        end
    end

    // each channel is ready while its holder is empty; level interrupt from the mask
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign s_axi_arready = !s_axi_rvalid;
    assign irq = |(status & mask);

    // phase sequencing: q1..q4 then back, frozen while asleep
    always_comb begin
        next_phase = phase;
        case (phase)
            st_idle: next_phase = pending ? st_q1 : st_idle;
            st_q1: next_phase = st_q2;
            st_q2: next_phase = st_q3;
            st_q3: next_phase = st_q4;
            st_q4: next_phase = st_idle;
            default: next_phase = st_idle;
        endcase
    end

    // phase register; holds still while asleep or while ce is low, so
    // sleep freezes the pass at idle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= st_idle;
        end else if (run) begin
            phase <= next_phase;
        end
    end

    // q2 latches the file register contents for the instruction; the memory
    // read launched in q1 is what stands here, before any q4 write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            read_val <= '0;
        end else if (run && phase == st_q2) begin
            read_val <= mem_rdata;
        end
    end

    // instruction queue: one word, taken when idle
    // a word written while one is pending or while asleep is dropped with an
    // okay answer: software must poll the pending bit before the next word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr <= '0;
            pending <= 1'b0;
        end else if (ce) begin
            if (wr_instr && !pending && !asleep) begin
                instr <= w_data[15:0];
                pending <= 1'b1;
            end else if (run && phase == st_q4) begin
                pending <= 1'b0;
            end
        end
    end

    // bank select register written by software; only lane 0 carries it
    // and the a bit decides per instruction whether it is used at all
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bank_select_reg <= '0;
        end else if (ce && wr_bank && w_strb[0]) begin
            bank_select_reg <= w_data[3:0];
        end
    end

    // power flags and sleep state; flags are set at reset like a power-on
    // sleep and wake cannot meet in one cycle: sleep needs a running core,
    // wake needs a sleeping one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
            asleep <= 1'b0;
            alu_flags <= '0;
        end else if (ce) begin
            if (run && wdt_clear) begin
                powerdown_flag <= 1'b0;
                timeout_flag <= 1'b1;
                asleep <= 1'b1;
            end else if (wdt_wake) begin
                timeout_flag <= 1'b0;
                asleep <= 1'b0;
            end
            alu_flags <= alu_flags;
        end
    end

    // oscillator request straight from the sleep state, no extra delay
    assign osc_run = !asleep;

    // interrupt mask written by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask <= '0;
        end else if (ce && wr_mask && w_strb[0]) begin
            mask <= w_data[ev_w-1:0];
        end
    end

    // sticky events, one flop per bit; an event in the same cycle as the
    // clearing read wins, so no event is lost to a read that just missed it
    for (genvar e = 0; e < ev_w; e++) begin : g_event
        logic held; // this event's sticky bit
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                held <= 1'b0;
            end else if (ce) begin
                if (ev_live[e]) begin
                    held <= 1'b1; // set beats the clearing read
                end else if (rd_status) begin
                    held <= 1'b0; // read of the status word clears
                end
            end
        end
        assign status[e] = held;
    end

    // write address capture; address and data are taken in either order,
    // each by its own holder, and both are freed when the response is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (b_done) begin
                aw_held <= 1'b0;
            end
        end
    end

    // write data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (ce) begin
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (b_done) begin
                w_held <= 1'b0;
            end
        end
    end

    // write response one edge after both halves are in; unmapped gives slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= resp_okay;
        end else if (ce) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? resp_okay : resp_slverr;
            end else if (b_done) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel: one read at a time, the answer stands until rready;
    // a status read clears the events as it is taken, data carry the old value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= resp_okay;
        end else if (ce) begin
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? resp_okay : resp_slverr;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // file registers run on the core's enable, so nothing moves while asleep;
    // the read launched in q1 is the one that q2 latches
    fso_data_mem u_mem (
        .aclk(aclk),
        .ce(run),
        .we(mem_we),
        .addr(eff_addr),
        .wdata(all_ones),
        .rdata(mem_rdata)
    );

    // watchdog keeps counting during sleep; only the sleep pass clears it,
    // so its interval restarts from zero on entry
    fso_watchdog u_wdt (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .clear(wdt_clear && run),
        .count(wdt_count),
        .post(wdt_post)
    );

    // arithmetic flags are kept but never read by these two instructions
    wire unused_ok = &{1'b0, alu_flags};
endmodule : file_set_and_sleep_ops
`default_nettype wire

// File: rtl/fso_data_mem.sv
// small data memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module fso_data_mem (
    input wire logic aclk,
    input wire logic ce,
    input wire logic we,
    input wire logic [fso_pkg::addr_w-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    import fso_pkg::*;
    logic [7:0] mem [0:(1<<addr_w)-1]; // file registers, no reset: contents are software's
    // one write and one read per cycle; a read of the address being written gives the old contents
    always_ff @(posedge aclk) begin
        if (ce && we) begin
            mem[addr] <= wdata;
        end
        if (ce) begin
            rdata <= mem[addr];
        end
    end
endmodule : fso_data_mem
`default_nettype wire

// File: rtl/fso_pkg.sv
// shared constants for the set-all-ones / sleep execution block
package fso_pkg;
    localparam int addr_w = 12; // data memory address width
    localparam logic [7:0] all_ones = 8'hff; // value written by the set instruction
    localparam logic [6:0] set_opcode_hi = 7'h34; // bits 15:9 of the set instruction
    localparam logic [15:0] sleep_opcode = 16'h0003; // full sleep instruction word
    localparam int a_bit = 8; // bank-routing operand bit
    localparam logic [3:0] access_bank = 4'h0; // shared low bank for addresses 00h-7fh
    localparam logic [3:0] access_bank_hi = 4'hf; // shared bank for addresses 80h-ffh
    localparam logic [11:0] axi_ctrl = 12'h000; // control: bit0 wdt wake request
    localparam logic [11:0] axi_status = 12'h004; // sticky events, cleared on read
    localparam logic [11:0] axi_mask = 12'h008; // interrupt mask
    localparam logic [11:0] axi_flags = 12'h00c; // flags, bank, sleep state
    localparam logic [11:0] axi_instr = 12'h010; // instruction word to execute
    localparam logic [11:0] axi_bank = 12'h014; // bank select value
    localparam int ev_set = 0; // status bit: set instruction done
    localparam int ev_sleep = 1; // status bit: sleep entered
    localparam int ev_wake = 2; // status bit: woke up
    localparam int ev_w = 3; // number of events
    localparam logic [1:0] resp_okay = 2'b00; // axi okay
    localparam logic [1:0] resp_slverr = 2'b10; // axi slave error
endpackage : fso_pkg

// File: rtl/fso_watchdog.sv
// watchdog counter with postscaler, clearable by the core
`timescale 1ns/1ps
`default_nettype none
module fso_watchdog (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic clear,
    output logic [7:0] count,
    output logic [7:0] post
);
    import fso_pkg::*;
    // counter runs freely; post advances on counter wrap
    always_ff @(posedge aclk) begin
        if (!aresetn || (ce && clear)) begin
            count <= '0;
            post <= '0;
        end else if (ce) begin
            count <= count + 8'h01;
            if (count == all_ones) begin
                post <= post + 8'h01;
            end
        end
    end
endmodule : fso_watchdog
`default_nettype wire

// File: tb/file_set_and_sleep_ops_monitor.sv
// port checker for the set-all-ones / sleep block
`timescale 1ns/1ps
`default_nettype none
module fso_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic osc_run,
    input wire logic irq
);
    import fso_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // both write halves taken at one edge, as the bench offers them
    wire logic aw_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire logic wr_instr = aw_hs && s_axi_awaddr == axi_instr;
    wire logic wr_wake = aw_hs && s_axi_awaddr == axi_ctrl && s_axi_wdata[0];
    wire logic wr_mask0 = aw_hs && s_axi_awaddr == axi_mask && s_axi_wdata[2:0] == 3'h0;
    wire logic is_sleep = s_axi_wdata[15:0] == sleep_opcode;
    // cycles since the last wake request, saturating so old requests age out
    logic [3:0] since_wake;
    always_ff @(posedge aclk) begin
        if (!aresetn) since_wake <= 4'hf;
        else if (wr_wake) since_wake <= 4'h0;
        else if (since_wake != 4'hf) since_wake <= since_wake + 4'h1;
    end
    a_sleep_halts_osc: assert property (wr_instr && is_sleep && osc_run |-> ##[2:10] !osc_run)
        else $error("sleep did not halt the oscillator");
    a_asleep_stays_put: assert property (!osc_run && !wr_wake && since_wake == 4'hf |=> !osc_run)
        else $error("woke without a wake request");
    a_wake_has_cause: assert property ($rose(osc_run) |-> since_wake < 4'h4)
        else $error("oscillator restarted with no recent wake");
    a_wake_restarts: assert property (wr_wake && !osc_run |-> ##[1:3] osc_run)
        else $error("wake request ignored");
    a_mask_quiet: assert property (wr_mask0 |-> ##2 !irq [*3])
        else $error("irq high with all events masked");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > axi_bank
        |=> s_axi_rresp == resp_slverr)
        else $error("unmapped read not refused");
    a_write_answer: assert property (aw_hs |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_reset_idle: assert property (disable iff (1'b0) !aresetn
        |=> !s_axi_bvalid && !s_axi_rvalid && osc_run && !irq)
        else $error("outputs not idle in reset");
    c_set: cover property (wr_instr && s_axi_wdata[15:9] == set_opcode_hi);
    c_sleep: cover property ($fell(osc_run));
    c_wake: cover property ($rose(osc_run));
endmodule : fso_monitor
bind file_set_and_sleep_ops fso_monitor mon (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .osc_run(osc_run), .irq(irq)
);
`default_nettype wire

// File: tb/file_set_and_sleep_ops_test.sv
// self-checking bench for the set-all-ones / sleep block
`timescale 1ns/1ps
`default_nettype none
module file_set_and_sleep_ops_test;
    import fso_pkg::*;
    logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic osc_run, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp, fl0;
    int errors = 0;
    int samples_checked = 0;
    file_set_and_sleep_ops uut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .osc_run(osc_run), .irq(irq));
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    // one write, each half held until its own ready
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    // one read; data and response taken at the rvalid edge
    task automatic rd_reg(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd_reg
    // an instruction must be finished five cycles after its write answer
    task automatic run_instr(input logic [15:0] w);
        wr(axi_instr, {16'h0000, w});
        repeat (5) @(posedge aclk);
        rd_reg(axi_instr);
        check("pending", {31'h0, rd[31]}, 32'h0);
    endtask : run_instr
    task automatic t_reset;
        rd_reg(axi_flags);
        fl0 = rd[2:1];
        check("idle flags", {24'h0, rd[7:0]} & 32'h82, 32'h02);
        check("idle osc", {30'h0, osc_run, irq}, 32'h2);
        $display("test reset done");
    endtask : t_reset
    // bank, opcode, and whether the q2 read must already show all ones
    logic [3:0] bk [6] = '{4'h0, 4'h5, 4'h5, 4'h5, 4'h5, 4'hf};
    logic [15:0] op [6] = '{16'h6920, 16'h6820, 16'h6920, 16'h6920, 16'h6890, 16'h6990};
    logic ff [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    task automatic t_set;
        for (int i = 0; i < 6; i++) begin
            wr(axi_bank, {28'h0, bk[i]});
            run_instr(op[i]);
            rd_reg(axi_flags);
            check("q2 read", {31'h0, rd[15:8] === all_ones}, {31'h0, ff[i]});
            check("bank", {28'h0, rd[6:3]}, {28'h0, bk[i]});
            check("flags kept", {30'h0, rd[2:1]}, {30'h0, fl0});
        end
        rd_reg(axi_status);
        check("set event", {29'h0, rd[2:0]}, 32'h1);
        $display("test set done");
    endtask : t_set
    task automatic t_sleep;
        wr(axi_mask, 32'h7);
        run_instr(sleep_opcode);
        rd_reg(axi_flags);
        check("sleep flags", {24'h0, rd[7:0]} & 32'h86, 32'h82);
        check("wdt restarted", {31'h0, rd[31:16] < 16'h0010}, 32'h1);
        check("osc halted", {30'h0, osc_run, irq}, 32'h1);
        run_instr(16'h69ff);
        rd_reg(axi_status);
        check("no exec asleep", {29'h0, rd[2:0]}, 32'h2);
        @(posedge aclk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        wr(axi_ctrl, 32'h1);
        repeat (3) @(posedge aclk);
        rd_reg(axi_flags);
        check("wake flags", {23'h0, osc_run, rd[7:0]} & 32'h186, 32'h100);
        rd_reg(axi_status);
        check("wake event", {29'h0, rd[2:0]}, 32'h4);
        wr(axi_mask, 32'h0);
        run_instr(sleep_opcode);
        check("masked irq", {31'h0, irq}, 32'h0);
        rd_reg(axi_flags);
        check("timeout set", {24'h0, rd[7:0]} & 32'h86, 32'h82);
        wr(axi_mask, 32'h2);
        @(posedge aclk);
        check("unmasked irq", {31'h0, irq}, 32'h1);
        wr(axi_ctrl, 32'h1);
        rd_reg(axi_status);
        $display("test sleep done");
    endtask : t_sleep
    task automatic t_unmapped;
        rd_reg(12'h020);
        check("read unmapped", {30'h0, rsp}, {30'h0, resp_slverr});
        wr(12'h018, 32'h1);
        check("write unmapped", {30'h0, rsp}, {30'h0, resp_slverr});
        rd_reg(axi_mask);
        check("read mapped", {30'h0, rsp}, {30'h0, resp_okay});
        $display("test unmapped done");
    endtask : t_unmapped
    initial begin
        aresetn = 1'b0;
        ce = 1'b1;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_set();
        t_sleep();
        t_unmapped();
        results();
    end
    // cuts a hang short well after the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        results();
    end
endmodule : file_set_and_sleep_ops_test
`default_nettype wire
